//--- verilog/rot_map.svh
// Purpose: Register offsets, field positions, reset values and counts for the reference oscillator tuning block
// Assumes: Included by bare name
// Notes: Field macros expand to bit ranges
`ifndef ROT_MAP_SVH
`define ROT_MAP_SVH
`define ROT_DEV_ADDR 7'h68
`define ROT_RA_DIV1 8'h0c
`define ROT_RA_WP 8'h11
`define ROT_RA_OSC 8'h12
`define ROT_RA_CAP 8'h13
`define ROT_RA_CONV 8'h14
`define ROT_RA_EFF 8'h15
`define ROT_RA_XPT0 8'h44
`define ROT_RA_XPT1 8'h45
`define ROT_RA_XPT2 8'h46
`define ROT_RA_DIV2 8'h47
`define ROT_TADDR_F 7:6
`define ROT_CAPSRC_B 5
`define ROT_GAIN_F 4:3
`define ROT_OSC_KEEP_F 7:3
`define ROT_CONVEN_B 7
`define ROT_CONVBYP_B 6
`define ROT_CONVCNT_F 5:3
`define ROT_CONVFLT_F 2:1
`define ROT_CONV_KEEP_F 7:1
`define ROT_PROTECT_PIN_SOURCE_B 3
`define ROT_DIVSRC_B 7
`define ROT_DIVN_F 6:0
`define ROT_OSC_RST 8'h20
`define ROT_CAP_RST 8'h00
`define ROT_CAP_EXT 8'h01
`define ROT_CONV_RST 8'h00
`define ROT_DIV_RST 8'h00
`define ROT_XPT_RST 8'h00
`define ROT_XPT1_ONES 8'h0e
`define ROT_XPT2_ONES 8'h07
`define ROT_TA_SERIAL 2'b00
`define ROT_TA_CONV 2'b01
`define ROT_CONV_DIG 7'h00
`define ROT_CONV_VOLT 7'h46
`define ROT_STRAP_WAIT 2'h2
`endif

//--- verilog/rot_pkg.sv
// Purpose: Types shared by the reference oscillator tuning block
// Assumes: Nothing
// Notes: Serial slave states are one-hot
package rot_pkg;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ADDR = 5'h02,
		ST_PTR = 5'h04,
		ST_WDATA = 5'h08,
		ST_RDATA = 5'h10
	} rot_ser_st_t;
endpackage

//--- verilog/rot_cfg_if.sv
// Purpose: Oscillator tuning settings passed from the register file to the capacitor selector
// Assumes: One clock domain
// Notes: None
`timescale 1ns/10ps
interface rot_cfg_if;
	logic [1:0] tune_addr_source;
	logic cap_value_source;
	logic [7:0] load_cap_code;
	logic conv_enable;
	logic conv_bypass_count;
	logic [2:0] conv_count;
	logic [1:0] conv_filter;
	logic [7:0] conv_sample;
	logic [7:0] cap_eff;
	modport ctrl (output tune_addr_source, cap_value_source, load_cap_code, conv_enable, conv_bypass_count,
		conv_count, conv_filter, conv_sample, input cap_eff);
	modport tune (input tune_addr_source, cap_value_source, load_cap_code, conv_enable, conv_bypass_count,
		conv_count, conv_filter, conv_sample, output cap_eff);
endinterface

//--- verilog/rot_cap_tune.sv
// Purpose: Chooses the oscillator load capacitance from the serial code or the stored table
// Assumes: Converter samples arrive on mclk
// Notes: Table index comes from the serial code or the averaged, filtered converter value
`timescale 1ns/10ps
`include "rot_map.svh"
module rot_cap_tune
	import rot_pkg::*;
(
	input wire logic mclk, // System clock
	input wire logic reset, // Synchronous reset
	rot_cfg_if.tune cfg // Settings in, capacitance out
);
	logic [7:0] tune_tab [256];
	logic [14:0] acc_q;
	logic [6:0] smp_cnt_q;
	logic [7:0] filt_q;
	// Default stored values: linear across the tuning range
	generate
		for (genvar g = 0; g < 256; g++)
		begin : g_tab
			assign tune_tab[g] = 8'(g);
		end
	endgenerate
	wire [7:0] smp_span = 8'(8'h01 << cfg.conv_count);
	wire [6:0] smp_last = 7'(smp_span - 8'h01);
	wire [14:0] acc_sum = 15'(acc_q + {7'h00, cfg.conv_sample});
	wire avg_rdy = cfg.conv_enable & (cfg.conv_bypass_count | (smp_cnt_q == smp_last));
	wire [7:0] avg_new = cfg.conv_bypass_count ? cfg.conv_sample : 8'(acc_sum >> cfg.conv_count);
	wire signed [8:0] diff = $signed({1'b0, avg_new}) - $signed({1'b0, filt_q});
	wire signed [8:0] step = diff >>> cfg.conv_filter;
	wire [7:0] filt_nx = 8'(filt_q + step[7:0]);
	wire [7:0] tab_addr = (cfg.tune_addr_source == `ROT_TA_CONV) ? filt_q : cfg.load_cap_code;
	assign cfg.cap_eff = cfg.cap_value_source ? cfg.load_cap_code : tune_tab[tab_addr];
	always_ff @(posedge mclk)
	begin
		if (reset || !cfg.conv_enable || avg_rdy)
		begin
			acc_q <= 15'h0000;
			smp_cnt_q <= 7'h00;
		end
		else
		begin
			acc_q <= acc_sum;
			smp_cnt_q <= 7'(smp_cnt_q + 7'h01);
		end
	end
	always_ff @(posedge mclk)
	begin
		if (reset)
			filt_q <= 8'h00;
		else if (avg_rdy)
			filt_q <= filt_nx;
	end
endmodule

//--- verilog/rot_osc_tuning.sv
// Purpose: Serial-programmed configuration of the reference oscillator, tuning and output sources
// Assumes: Two-wire host on serial_clk_pin and serial_data_pin; converter samples on mclk
// Notes: Open-drain data pin; oe_n low means the pin is pulled low
`timescale 1ns/10ps
`include "rot_map.svh"
module rot_osc_tuning
	import rot_pkg::*;
(
	input wire logic mclk, // 25 MHz clock
	input wire logic reset, // Synchronous, active high
	input wire logic serial_clk_pin, // Serial clock pin
	input wire logic serial_data_pin_in, // Serial data pin level
	output logic serial_data_pin_out, // Serial data drive value
	output logic serial_data_pin_oe_n, // Low pulls the data pin
	input wire logic ref_is_external, // Strap: external clock reference
	input wire logic [7:0] conv_sample, // Converter sample, mclk domain
	output logic [1:0] osc_gain_sel, // Oscillator gain code
	output logic [1:0] tune_addr_source, // Table index source
	output logic cap_value_source, // 1: code drives caps directly
	output logic [7:0] load_cap_code, // Load capacitor code
	output logic [7:0] osc_load_cap, // Capacitance applied to oscillator
	output logic conv_enable, // Converter enable
	output logic conv_bypass_count, // Converter count bypass
	output logic [2:0] conv_count, // Converter averaging count
	output logic [1:0] conv_filter, // Converter filter shift
	output logic protect_pin_source, // Protect pin function select
	output logic [6:0] bank1_divisor, // Bank 1 divisor
	output logic bank1_src_sel, // Bank 1 input select
	output logic [6:0] bank2_divisor, // Bank 2 divisor
	output logic bank2_src_sel, // Bank 2 input select
	output logic [17:0] clk_src_sel, // Source codes, output 1 in top bits
	output logic digital_tuned_osc_mode, // Digital tuning configured
	output logic voltage_tuned_osc_mode // Voltage tuning configured
);
	rot_ser_st_t state_q;
	logic [2:0] scl_sync_q;
	logic [2:0] sda_sync_q;
	logic [1:0] ext_sync_q;
	logic [1:0] strap_cnt_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic [7:0] ptr_q;
	logic [7:0] rd_sh_q;
	logic mack_q;
	logic oe_n_q;
	logic [7:0] osc_q;
	logic [7:0] cap_q;
	logic [7:0] conv_q;
	logic prot_q;
	logic [7:0] div1_q;
	logic [7:0] div2_q;
	logic [7:0] xpt0_q;
	logic [7:0] xpt1_q;
	logic [7:0] xpt2_q;
	logic [7:0] osc_cap_q;
	logic dig_q;
	logic volt_q;
	rot_cfg_if cfg_if ();

	// Second stage feeds logic; third stage is the previous level for edges
	wire scl_rise = scl_sync_q[1] & ~scl_sync_q[2];
	wire scl_fall = ~scl_sync_q[1] & scl_sync_q[2];
	wire bus_start = scl_sync_q[1] & scl_sync_q[2] & sda_sync_q[2] & ~sda_sync_q[1];
	wire bus_stop = scl_sync_q[1] & scl_sync_q[2] & ~sda_sync_q[2] & sda_sync_q[1];
	wire active = (state_q != ST_IDLE);
	wire byte_end = scl_fall & active & (bit_cnt_q == 4'h7);
	wire ack_end = scl_fall & active & (bit_cnt_q == 4'h8);
	wire addr_hit = (shift_q[7:1] == `ROT_DEV_ADDR);
	wire wr_stb = byte_end & (state_q == ST_WDATA);
	wire [7:0] wr_data = shift_q;
	wire strap_load = (strap_cnt_q == `ROT_STRAP_WAIT);
	wire [17:0] xpt_w = {xpt0_q, xpt1_q[7:4], xpt1_q[0], xpt2_q[7:3]};
	rot_ser_st_t state_nx;
	assign state_nx = (state_q == ST_ADDR) ? (addr_hit ? (shift_q[0] ? ST_RDATA : ST_PTR) : ST_IDLE) :
		(state_q == ST_PTR) ? ST_WDATA :
		((state_q == ST_RDATA) && !mack_q) ? ST_IDLE : state_q;
	wire [7:0] rd_byte = (ptr_q == `ROT_RA_DIV1) ? div1_q :
		(ptr_q == `ROT_RA_WP) ? {4'h0, prot_q, 3'h0} :
		(ptr_q == `ROT_RA_OSC) ? osc_q :
		(ptr_q == `ROT_RA_CAP) ? cap_q :
		(ptr_q == `ROT_RA_CONV) ? conv_q :
		(ptr_q == `ROT_RA_EFF) ? osc_cap_q :
		(ptr_q == `ROT_RA_XPT0) ? xpt0_q :
		(ptr_q == `ROT_RA_XPT1) ? (xpt1_q | `ROT_XPT1_ONES) :
		(ptr_q == `ROT_RA_XPT2) ? (xpt2_q | `ROT_XPT2_ONES) :
		(ptr_q == `ROT_RA_DIV2) ? div2_q : 8'h00;
	wire dig_w = (osc_q[`ROT_TADDR_F] == `ROT_TA_SERIAL) & ~osc_q[`ROT_CAPSRC_B] &
		(conv_q[`ROT_CONV_KEEP_F] == `ROT_CONV_DIG);
	wire volt_w = (osc_q[`ROT_TADDR_F] == `ROT_TA_CONV) & ~osc_q[`ROT_CAPSRC_B] &
		(conv_q[`ROT_CONV_KEEP_F] == `ROT_CONV_VOLT) & prot_q;

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			scl_sync_q <= 3'h7;
			sda_sync_q <= 3'h7;
			ext_sync_q <= 2'h0;
		end
		else
		begin
			scl_sync_q <= {scl_sync_q[1:0], serial_clk_pin};
			sda_sync_q <= {sda_sync_q[1:0], serial_data_pin_in};
			ext_sync_q <= {ext_sync_q[0], ref_is_external};
		end
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			strap_cnt_q <= 2'h0;
		else if (strap_cnt_q != 2'h3)
			strap_cnt_q <= 2'(strap_cnt_q + 2'h1);
	end

	always_ff @(posedge mclk)
	begin
		if (reset || bus_stop)
			state_q <= ST_IDLE;
		else if (bus_start)
			state_q <= ST_ADDR;
		else if (ack_end)
			state_q <= state_nx;
	end

	always_ff @(posedge mclk)
	begin
		if (reset || bus_stop || ack_end)
			bit_cnt_q <= 4'h0;
		// The clock fall that closes a START is no data bit: count it up to zero
		else if (bus_start)
			bit_cnt_q <= 4'hf;
		else if (scl_fall && active)
			bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			shift_q <= 8'h00;
			mack_q <= 1'b0;
		end
		else if (scl_rise && bit_cnt_q < 4'h8)
			shift_q <= {shift_q[6:0], sda_sync_q[1]};
		else if (scl_rise && bit_cnt_q == 4'h8)
			mack_q <= ~sda_sync_q[1];
	end

	// Pointer auto-increments after each written data byte and as each read byte is loaded
	always_ff @(posedge mclk)
	begin
		if (reset)
			ptr_q <= 8'h00;
		else if (byte_end && state_q == ST_PTR)
			ptr_q <= wr_data;
		else if (ack_end && (state_q == ST_WDATA || state_nx == ST_RDATA))
			ptr_q <= 8'(ptr_q + 8'h01);
	end

	always_ff @(posedge mclk)
	begin
		if (reset || bus_start || bus_stop)
		begin
			oe_n_q <= 1'b1;
			rd_sh_q <= 8'h00;
		end
		else if (byte_end)
			oe_n_q <= (state_q == ST_ADDR) ? ~addr_hit : (state_q == ST_RDATA);
		else if (ack_end)
		begin
			oe_n_q <= (state_nx == ST_RDATA) ? rd_byte[7] : 1'b1;
			rd_sh_q <= rd_byte;
		end
		else if (scl_fall && state_q == ST_RDATA && bit_cnt_q < 4'h7)
		begin
			oe_n_q <= rd_sh_q[6];
			rd_sh_q <= {rd_sh_q[6:0], 1'b0};
		end
	end

	// Written values reach the outputs on the next edge, no commit step
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			osc_q <= `ROT_OSC_RST;
			conv_q <= `ROT_CONV_RST;
			prot_q <= 1'b0;
			div1_q <= `ROT_DIV_RST;
			div2_q <= `ROT_DIV_RST;
			xpt0_q <= `ROT_XPT_RST;
			xpt1_q <= `ROT_XPT_RST;
			xpt2_q <= `ROT_XPT_RST;
		end
		else if (wr_stb)
		begin
			if (ptr_q == `ROT_RA_OSC)
				osc_q <= {wr_data[`ROT_OSC_KEEP_F], 3'h0};
			if (ptr_q == `ROT_RA_CONV)
				conv_q <= {wr_data[`ROT_CONV_KEEP_F], 1'b0};
			if (ptr_q == `ROT_RA_WP)
				prot_q <= wr_data[`ROT_PROTECT_PIN_SOURCE_B];
			if (ptr_q == `ROT_RA_DIV1)
				div1_q <= wr_data;
			if (ptr_q == `ROT_RA_DIV2)
				div2_q <= wr_data;
			if (ptr_q == `ROT_RA_XPT0)
				xpt0_q <= wr_data;
			if (ptr_q == `ROT_RA_XPT1)
				xpt1_q <= wr_data;
			if (ptr_q == `ROT_RA_XPT2)
				xpt2_q <= wr_data;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			cap_q <= `ROT_CAP_RST;
		else if (strap_load)
			cap_q <= ext_sync_q[1] ? `ROT_CAP_EXT : `ROT_CAP_RST;
		else if (wr_stb && ptr_q == `ROT_RA_CAP)
			cap_q <= wr_data;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			osc_cap_q <= `ROT_CAP_RST;
			dig_q <= 1'b0;
			volt_q <= 1'b0;
		end
		else
		begin
			osc_cap_q <= cfg_if.cap_eff;
			dig_q <= dig_w;
			volt_q <= volt_w;
		end
	end

	assign cfg_if.tune_addr_source = osc_q[`ROT_TADDR_F];
	assign cfg_if.cap_value_source = osc_q[`ROT_CAPSRC_B];
	assign cfg_if.load_cap_code = cap_q;
	assign cfg_if.conv_enable = conv_q[`ROT_CONVEN_B];
	assign cfg_if.conv_bypass_count = conv_q[`ROT_CONVBYP_B];
	assign cfg_if.conv_count = conv_q[`ROT_CONVCNT_F];
	assign cfg_if.conv_filter = conv_q[`ROT_CONVFLT_F];
	assign cfg_if.conv_sample = conv_sample;

	rot_cap_tune u_tune (
		.mclk(mclk),
		.reset(reset),
		.cfg(cfg_if.tune)
	);

	assign serial_data_pin_out = 1'b0;
	assign serial_data_pin_oe_n = oe_n_q;
	assign osc_gain_sel = osc_q[`ROT_GAIN_F];
	assign tune_addr_source = osc_q[`ROT_TADDR_F];
	assign cap_value_source = osc_q[`ROT_CAPSRC_B];
	assign load_cap_code = cap_q;
	assign osc_load_cap = osc_cap_q;
	assign conv_enable = conv_q[`ROT_CONVEN_B];
	assign conv_bypass_count = conv_q[`ROT_CONVBYP_B];
	assign conv_count = conv_q[`ROT_CONVCNT_F];
	assign conv_filter = conv_q[`ROT_CONVFLT_F];
	assign protect_pin_source = prot_q;
	assign bank1_divisor = div1_q[`ROT_DIVN_F];
	assign bank1_src_sel = div1_q[`ROT_DIVSRC_B];
	assign bank2_divisor = div2_q[`ROT_DIVN_F];
	assign bank2_src_sel = div2_q[`ROT_DIVSRC_B];
	assign clk_src_sel = xpt_w;
	assign digital_tuned_osc_mode = dig_q;
	assign voltage_tuned_osc_mode = volt_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	chk_gain_write: assert property ((wr_stb && ptr_q == `ROT_RA_OSC && wr_data[4:3] == 2'b10)
		|=> osc_gain_sel == 2'b10) else $error("gain code not taken from bits 4:3");
	chk_reserved_zero: assert property (wr_stb && ptr_q == `ROT_RA_OSC |=> osc_q[2:0] == 3'h0)
		else $error("reserved drive bits stored");
	chk_cap_write: assert property ((wr_stb && ptr_q == `ROT_RA_CAP && !strap_load)
		|=> load_cap_code == $past(wr_data)) else $error("load code write lost");
	chk_cap_direct: assert property ((osc_q[`ROT_TADDR_F] == `ROT_TA_SERIAL && $stable(cap_q)) [*3]
		|-> osc_load_cap == cap_q) else $error("digital tuning not applied");
	chk_addr_reset: assert property ($fell(reset) |-> tune_addr_source == 2'b00 && cap_value_source)
		else $error("tuning source reset wrong");
	chk_ext_default: assert property (strap_load && ext_sync_q[1] |=> load_cap_code == 8'h01)
		else $error("external reference default missing");
	chk_bank_indep: assert property (wr_stb && ptr_q == `ROT_RA_DIV1 |=> $stable(div2_q))
		else $error("bank 2 disturbed");
	chk_ptr_step: assert property (ack_end && state_q == ST_WDATA |=> ptr_q == 8'($past(ptr_q) + 8'h01))
		else $error("pointer did not advance");
	chk_addr_ack: assert property (byte_end && state_q == ST_ADDR && addr_hit |=> !serial_data_pin_oe_n)
		else $error("address not acknowledged");
	chk_volt_mode: assert property (volt_w |=> voltage_tuned_osc_mode && !digital_tuned_osc_mode)
		else $error("voltage mode flag wrong");
	chk_xpt_apply: assert property (wr_stb && ptr_q == `ROT_RA_XPT0 |=> clk_src_sel[17:15] == $past(wr_data[7:5]))
		else $error("crosspoint write not applied");
	cov_write: cover property (wr_stb && ptr_q == `ROT_RA_CAP);
	cov_read: cover property (ack_end && state_nx == ST_RDATA);
	cov_volt: cover property ($rose(voltage_tuned_osc_mode));
	cov_dig: cover property (digital_tuned_osc_mode && $changed(osc_load_cap));
endmodule

//--- verification/rot_host_model.sv
// Purpose: Two-wire host that programs the oscillator tuning registers
// Assumes: Data line pulled up outside; clock idles high
// Notes: Half periods of 10 mclk, data moves 5 mclk from clock edges
`timescale 1ns/10ps
`include "rot_map.svh"
module rot_host_model (
	input wire logic mclk, // System clock
	input wire logic sda, // Resolved data line
	output logic scl, // Serial clock
	output logic sda_oe_n // Low pulls data low
);
	logic [6:0] dev = `ROT_DEV_ADDR;
	logic ok;
	initial
	begin
		scl = 1'b1;
		sda_oe_n = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic bit_x(input logic b, output logic s);
		sda_oe_n <= b;
		tick(5);
		scl <= 1'b1;
		tick(10);
		s = sda;
		scl <= 1'b0;
		tick(5);
	endtask
	task automatic start();
		sda_oe_n <= 1'b0;
		tick(10);
		scl <= 1'b0;
		tick(5);
	endtask
	task automatic stop();
		sda_oe_n <= 1'b0;
		tick(5);
		scl <= 1'b1;
		tick(10);
		sda_oe_n <= 1'b1;
		tick(10);
	endtask
	// Byte out MSB first, line released for the ninth bit
	task automatic xfer(input logic [7:0] b, output logic [7:0] r);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_x(b[i], s);
			r[i] = s;
		end
		bit_x(1'b1, s);
		ok = ok & ~s;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		ok = 1'b1;
		start();
		xfer({dev, 1'b0}, r);
		xfer(a, r);
		xfer(d, r);
		stop();
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] r;
		start();
		xfer({dev, 1'b0}, r);
		xfer(a, r);
		stop();
		start();
		xfer({dev, 1'b1}, r);
		xfer(8'hff, d);
		stop();
	endtask
endmodule

//--- verification/rot_osc_tuning_bench.sv
// Purpose: Self-checking bench for the oscillator tuning block
// Assumes: Host model on the serial pins; converter sample held steady
// Notes: Stored table is identity, so table outputs equal the index
`timescale 1ns/10ps
`include "rot_map.svh"
module rot_osc_tuning_bench
	import rot_pkg::*;
;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic ext = 1'b0;
	logic [7:0] smp = 8'h37;
	wire logic scl, h_oe_n, d_oe_n;
	wire logic sda = h_oe_n & d_oe_n;
	logic [1:0] osc_gain_sel, tune_addr_source, conv_filter;
	logic [7:0] load_cap_code, osc_load_cap;
	logic [2:0] conv_count;
	logic [6:0] bank1_divisor, bank2_divisor;
	logic [17:0] clk_src_sel;
	logic cap_value_source, conv_enable, conv_bypass_count, protect_pin_source;
	logic bank1_src_sel, bank2_src_sel, digital_tuned_osc_mode, voltage_tuned_osc_mode;
	int num_errors = 0;
	int compares = 0;
	int cyc = 0;
	always #20 mclk = ~mclk;
	rot_host_model u_host (.mclk, .sda, .scl, .sda_oe_n(h_oe_n));
	rot_osc_tuning u_dut (.mclk, .reset, .serial_clk_pin(scl), .serial_data_pin_in(sda),
		.serial_data_pin_out(), .serial_data_pin_oe_n(d_oe_n), .ref_is_external(ext), .conv_sample(smp),
		.osc_gain_sel, .tune_addr_source, .cap_value_source, .load_cap_code, .osc_load_cap, .conv_enable,
		.conv_bypass_count, .conv_count, .conv_filter, .protect_pin_source, .bank1_divisor, .bank1_src_sel,
		.bank2_divisor, .bank2_src_sel, .clk_src_sel, .digital_tuned_osc_mode, .voltage_tuned_osc_mode);
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_host.rd(a, d);
		chk($sformatf("reg %h", a), e, d);
	endtask
	task automatic do_reset();
		reset <= 1'b1;
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		repeat (6) @(posedge mclk);
	endtask
	task automatic t_reset();
		chk("addr_src", 2'b00, tune_addr_source);
		chk("cap_src", 1'b1, cap_value_source);
		rchk(`ROT_RA_OSC, 8'h20);
		rchk(`ROT_RA_CAP, 8'h00);
		rchk(`ROT_RA_CONV, 8'h00);
	endtask
	task automatic t_gain();
		for (int g = 0; g < 4; g++)
		begin
			u_host.wr(`ROT_RA_OSC, {3'b001, g[1:0], 3'b000});
			chk("gain", g[1:0], osc_gain_sel);
			rchk(`ROT_RA_OSC, {3'b001, g[1:0], 3'b000});
		end
	endtask
	task automatic t_cap();
		u_host.wr(`ROT_RA_CAP, 8'h5a);
		chk("load_code", 8'h5a, load_cap_code);
		chk("load_cap", 8'h5a, osc_load_cap);
	endtask
	task automatic t_digital_tuned_osc_mode();
		u_host.wr(`ROT_RA_OSC, 8'h08);
		u_host.wr(`ROT_RA_CONV, 8'h00);
		chk("dig_mode", 1'b1, digital_tuned_osc_mode);
		u_host.wr(`ROT_RA_CAP, 8'h00);
		chk("load_cap", 8'h00, osc_load_cap);
		u_host.wr(`ROT_RA_CAP, 8'hff);
		chk("load_cap", 8'hff, osc_load_cap);
		rchk(`ROT_RA_EFF, 8'hff);
	endtask
	task automatic t_voltage_tuned_osc_mode();
		u_host.wr(`ROT_RA_WP, 8'h08);
		u_host.wr(`ROT_RA_OSC, 8'h48);
		u_host.wr(`ROT_RA_CONV, 8'h8c);
		chk("volt_mode", 1'b1, voltage_tuned_osc_mode);
		chk("dig_mode", 1'b0, digital_tuned_osc_mode);
		chk("conv", 7'h46, {conv_enable, conv_bypass_count, conv_count, conv_filter});
		chk("addr_src", 2'b01, tune_addr_source);
		chk("wp_src", 1'b1, protect_pin_source);
		rchk(`ROT_RA_CONV, 8'h8c);
		rchk(`ROT_RA_WP, 8'h08);
		chk("voltage_tuned_osc_mode_cap", 6'h0d, osc_load_cap[7:2]);
	endtask
	task automatic t_route();
		u_host.wr(`ROT_RA_DIV1, 8'h85);
		u_host.wr(`ROT_RA_DIV2, 8'h1a);
		chk("bank1", 8'h85, {bank1_src_sel, bank1_divisor});
		chk("bank2", 8'h1a, {bank2_src_sel, bank2_divisor});
		u_host.wr(`ROT_RA_XPT0, 8'hfa);
		u_host.wr(`ROT_RA_XPT1, 8'hc1);
		u_host.wr(`ROT_RA_XPT2, 8'hb8);
		chk("src_sel", {8'hfa, 4'hc, 1'b1, 5'h17}, clk_src_sel);
		rchk(`ROT_RA_XPT1, 8'hcf);
		rchk(`ROT_RA_XPT2, 8'hbf);
		rchk(`ROT_RA_DIV1, 8'h85);
		rchk(`ROT_RA_DIV2, 8'h1a);
	endtask
	task automatic t_bad();
		u_host.wr(8'h30, 8'h5a);
		chk("ack", 1'b1, u_host.ok);
		rchk(8'h30, 8'h00);
		u_host.dev = 7'h55;
		u_host.wr(`ROT_RA_CAP, 8'h33);
		chk("ack", 1'b0, u_host.ok);
		u_host.dev = `ROT_DEV_ADDR;
		rchk(`ROT_RA_CAP, 8'hff);
	endtask
	task automatic t_strap();
		ext <= 1'b1;
		do_reset();
		chk("load_code", 8'h01, load_cap_code);
		rchk(`ROT_RA_CAP, 8'h01);
	endtask
	task automatic summarize();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 80000)
		begin
			num_errors++;
			summarize();
		end
	end
	initial
	begin
		do_reset();
		t_reset();
		t_gain();
		t_cap();
		t_digital_tuned_osc_mode();
		t_voltage_tuned_osc_mode();
		t_route();
		t_bad();
		t_strap();
		summarize();
	end
endmodule
